// [common/rsf_map.svh]
`ifndef RSF_MAP_SVH
`define RSF_MAP_SVH
`define RSF_OFF_FLAGS     32'h0000_7ff0
`define RSF_OFF_CENTURY   32'h0000_7ff1
`define RSF_OFF_CENT_BYTE 32'h0001_ffc4
`define RSF_OFF_FLAGS_B   32'h0001_ffc0
`define RSF_OFF_CTRL      32'h0000_0000
`define RSF_OFF_STATUS    32'h0000_0004
`define RSF_BIT_PF        5
`define RSF_BIT_OSCILLATOR_FAIL_FLAG      4
`define RSF_BIT_UNUSED    3
`define RSF_CLK_MHZ       250
`define RSF_OSC_WAIT_MS   5
`define RSF_OSC_WAIT_CYC  (`RSF_OSC_WAIT_MS * 1000 * `RSF_CLK_MHZ)
`define RSF_XFER_NS       1000
`define RSF_XFER_CYC      ((`RSF_XFER_NS * `RSF_CLK_MHZ) / 1000)
`define RSF_CENT_MAX      8'h09
`define RSF_RST_BYTE      8'h00
`endif

// [common/rsf_pkg.sv]
package rsf_pkg;
   typedef enum logic [2:0] {
      RSF_ST_WAIT = 3'b001,
      RSF_ST_RUN  = 3'b010,
      RSF_ST_DONE = 3'b100
   } rsf_osc_e;
   typedef logic [7:0] rsf_byte_t;
endpackage : rsf_pkg

// [design/rsf_osc_check.sv]
`timescale 1ns/1ps
`include "rsf_map.svh"
// ****************************************
// Start-up oscillator watch.
// ****************************************
module rsf_osc_check
   import rsf_pkg::*;
#(
   parameter int unsigned WAIT_CYC = `RSF_OSC_WAIT_CYC
) (
   input  wire logic clk,
   input  wire logic rst,
   input  wire logic osc_enable,
   input  wire logic osc_tick,
   output logic      osc_fail_pulse,
   output logic      check_done
);
   rsf_osc_e    st_q, st_d;
   logic [31:0] cnt_q, cnt_d;
   logic        seen_q, seen_d;
   logic        fail_q, fail_d;

   always_comb begin
      st_d   = st_q;
      cnt_d  = cnt_q;
      seen_d = seen_q | osc_tick;
      fail_d = 1'b0;
      case (st_q)
         RSF_ST_WAIT: begin
            st_d = RSF_ST_RUN;
         end
         RSF_ST_RUN: begin
            cnt_d = cnt_q + 32'h0000_0001;
            if (cnt_q >= WAIT_CYC - 1) begin
               st_d   = RSF_ST_DONE;
               // A disabled oscillator is not a failure.
               fail_d = osc_enable & ~(seen_q | osc_tick);
            end
         end
         RSF_ST_DONE: begin
            st_d = RSF_ST_DONE;
         end
         default: begin
            st_d = RSF_ST_WAIT;
         end
      endcase
   end

   always_ff @(posedge clk) begin
      if (rst) begin
         st_q   <= RSF_ST_WAIT;
         cnt_q  <= 32'h0000_0000;
         seen_q <= 1'b0;
         fail_q <= 1'b0;
      end else begin
         st_q   <= st_d;
         cnt_q  <= cnt_d;
         seen_q <= seen_d;
         fail_q <= fail_d;
      end
   end

   assign osc_fail_pulse = fail_q;
   assign check_done     = (st_q == RSF_ST_DONE);
endmodule : rsf_osc_check

// [design/rsf_xfer_delay.sv]
`timescale 1ns/1ps
`include "rsf_map.svh"
// ****************************************
// Delayed write of one bit.
// ****************************************
module rsf_xfer_delay
   import rsf_pkg::*;
#(
   parameter int unsigned DELAY_CYC = `RSF_XFER_CYC
) (
   input  wire logic clk,
   input  wire logic rst,
   input  wire logic start,
   input  wire logic start_val,
   output logic      done,
   output logic      done_val,
   output logic      busy
);
   logic [31:0] cnt_q, cnt_d;
   logic        busy_q, busy_d;
   logic        val_q, val_d;
   logic        done_q, done_d;

   always_comb begin
      cnt_d  = cnt_q;
      busy_d = busy_q;
      val_d  = val_q;
      done_d = 1'b0;
      if (start) begin
         // A newer write restarts the delay with its own value.
         busy_d = 1'b1;
         val_d  = start_val;
         cnt_d  = 32'h0000_0000;
      end else if (busy_q) begin
         cnt_d = cnt_q + 32'h0000_0001;
         if (cnt_q >= DELAY_CYC - 1) begin
            busy_d = 1'b0;
            done_d = 1'b1;
         end
      end
   end

   always_ff @(posedge clk) begin
      if (rst) begin
         cnt_q  <= 32'h0000_0000;
         busy_q <= 1'b0;
         val_q  <= 1'b0;
         done_q <= 1'b0;
      end else begin
         cnt_q  <= cnt_d;
         busy_q <= busy_d;
         val_q  <= val_d;
         done_q <= done_d;
      end
   end

   assign done     = done_q;
   assign done_val = val_q;
   assign busy     = busy_q;
endmodule : rsf_xfer_delay

// [design/rsf_flags_top.sv]
// Implementation choice: register access over APB.
`timescale 1ns/1ps
`include "rsf_map.svh"
// Functional notes
// - Century count is BCD, ones digit low nibble, tens high, range 0 to 9.
// - Enabled oscillator idle for first 5 ms after power-up sets oscillator fail.
// - Oscillator fail flag is kept and never cleared by internal logic.
// - Written oscillator fail value appears only after the transfer delay.
// - Power fail flag clears on flags register read and at power-up.
module rsf_flags_top
   import rsf_pkg::*;
#(
   parameter int unsigned OSC_WAIT_CYC = `RSF_OSC_WAIT_CYC,
   parameter int unsigned XFER_CYC     = `RSF_XFER_CYC
) (
   input  wire logic        clk,
   input  wire logic        rst,
   input  wire logic        psel,
   input  wire logic        penable,
   input  wire logic        pwrite,
   input  wire logic [31:0] paddr,
   input  wire logic [31:0] pwdata,
   input  wire logic [3:0]  pstrb,
   output logic      [31:0] prdata,
   output logic             pready,
   output logic             pslverr,
   input  wire logic        osc_enable,
   input  wire logic        osc_tick,
   input  wire logic        power_fail_event,
   input  wire logic        oscillator_fail_flag_retained,
   output logic             oscillator_fail_flag,
   output logic             power_fail_flag,
   output logic      [7:0]  century_count
);
   // ****************************************
   // Register state.
   // ****************************************
   logic        oscillator_fail_flag_q, oscillator_fail_flag_d;
   logic        pf_q, pf_d;
   logic        load_q, load_d;
   rsf_byte_t   cent_q, cent_d;
   logic [31:0] rdata_q, rdata_d;
   logic        setup;
   logic        rd_flags;
   logic        wr_flags;
   logic        wr_cent;
   logic        fail_pulse;
   logic        chk_done;
   logic        x_done;
   logic        x_val;
   logic        x_busy;
   logic        acc;
   logic        wr;
   logic        rd;
   logic        hit_flags;
   logic        hit_cent;
   logic        hit_status;

   function automatic logic bcd_ok(input rsf_byte_t v);
      bcd_ok = (v <= `RSF_CENT_MAX);
   endfunction : bcd_ok

   function automatic logic [7:0] flags_byte(input logic o, input logic p);
      logic [7:0] b;
      b = 8'h00;
      b[`RSF_BIT_OSCILLATOR_FAIL_FLAG]   = o;
      b[`RSF_BIT_PF]     = p;
      b[`RSF_BIT_UNUSED] = 1'b0;
      flags_byte = b;
   endfunction : flags_byte

   function automatic logic [31:0] status_word(input logic busy, input logic done);
      status_word = {30'h0000_0000, busy, done};
   endfunction : status_word

   // Unmapped words read as zero; the error response is raised on its own path.
   function automatic logic [31:0] read_word(input logic [31:0] a,
                                             input logic        o,
                                             input logic        p,
                                             input rsf_byte_t   c,
                                             input logic [31:0] s);
      read_word = 32'h0000_0000;
      if (a == `RSF_OFF_FLAGS_B) begin
         read_word = {24'h00_0000, flags_byte(o, p)};
      end else if (a == `RSF_OFF_CENT_BYTE) begin
         read_word = {24'h00_0000, c};
      end else if (a == `RSF_OFF_STATUS) begin
         read_word = s;
      end
   endfunction : read_word

   // ****************************************
   // Helpers.
   // ****************************************
   rsf_osc_check #(
      .WAIT_CYC (OSC_WAIT_CYC)
   ) u_osc (
      .clk            (clk),
      .rst            (rst),
      .osc_enable     (osc_enable),
      .osc_tick       (osc_tick),
      .osc_fail_pulse (fail_pulse),
      .check_done     (chk_done)
   );

   rsf_xfer_delay #(
      .DELAY_CYC (XFER_CYC)
   ) u_xfer (
      .clk       (clk),
      .rst       (rst),
      .start     (wr_flags),
      .start_val (pwdata[`RSF_BIT_OSCILLATOR_FAIL_FLAG]),
      .done      (x_done),
      .done_val  (x_val),
      .busy      (x_busy)
   );

   // ****************************************
   // APB decode.
   // ****************************************
   assign acc        = psel && penable;
   assign setup      = psel && !penable;
   assign wr         = acc && pwrite;
   assign rd         = acc && !pwrite;
   assign rd_flags   = rd && hit_flags;
   assign wr_flags   = wr && hit_flags && pstrb[0];
   assign wr_cent    = wr && hit_cent && pstrb[0];
   assign hit_flags  = (paddr == `RSF_OFF_FLAGS_B);
   assign hit_cent   = (paddr == `RSF_OFF_CENT_BYTE);
   assign hit_status = (paddr == `RSF_OFF_STATUS);
   assign pready     = 1'b1;
   assign pslverr    = acc && !(hit_flags || hit_cent || hit_status);

   // ****************************************
   // Oscillator fail flag.
   // ****************************************
   always_comb begin
      oscillator_fail_flag_d = oscillator_fail_flag_q;
      load_d = 1'b0;
      // Retained flag value is picked up once, the cycle after power-up.
      if (load_q) begin
         oscillator_fail_flag_d = oscillator_fail_flag_retained;
      end
      // A host write moves the flag only once it has waited out the transfer delay.
      if (x_done) begin
         oscillator_fail_flag_d = x_val;
      end
      // A start-up failure wins over a delayed write landing in the same cycle.
      if (fail_pulse) begin
         oscillator_fail_flag_d = 1'b1;
      end
   end

   always_ff @(posedge clk) begin
      if (rst) begin
         oscillator_fail_flag_q <= 1'b0;
         load_q <= 1'b1;
      end else begin
         oscillator_fail_flag_q <= oscillator_fail_flag_d;
         load_q <= load_d;
      end
   end

   // ****************************************
   // Power fail flag.
   // ****************************************
   always_comb begin
      pf_d = pf_q;
      // Only a flag already handed out in the read word is cleared, so an event
      // that lands between capture and access is not lost.
      if (rd_flags && rdata_q[`RSF_BIT_PF]) begin
         pf_d = 1'b0;
      end
      // A new power failure wins over the clearing read.
      if (power_fail_event) begin
         pf_d = 1'b1;
      end
   end

   always_ff @(posedge clk) begin
      if (rst) begin
         pf_q <= 1'b0;
      end else begin
         pf_q <= pf_d;
      end
   end

   // ****************************************
   // Century count.
   // ****************************************
   always_comb begin
      cent_d = cent_q;
      // A word outside the BCD range is dropped, so the count never leaves 0 to 9.
      if (wr_cent && bcd_ok(pwdata[7:0])) begin
         cent_d = pwdata[7:0];
      end
   end

   always_ff @(posedge clk) begin
      if (rst) begin
         cent_q <= `RSF_RST_BYTE;
      end else begin
         cent_q <= cent_d;
      end
   end

   // ****************************************
   // Read data.
   // ****************************************
   always_comb begin
      rdata_d = rdata_q;
      // The word is caught in the setup phase, so the zero-wait access phase answers
      // from a register; the price is that it shows the state of the setup cycle.
      if (setup) begin
         rdata_d = read_word(paddr, oscillator_fail_flag_q, pf_q, cent_q, status_word(x_busy, chk_done));
      end
   end

   always_ff @(posedge clk) begin
      if (rst) begin
         rdata_q <= 32'h0000_0000;
      end else begin
         rdata_q <= rdata_d;
      end
   end

   assign prdata = rdata_q;

   assign oscillator_fail_flag = oscillator_fail_flag_q;
   assign power_fail_flag      = pf_q;
   assign century_count        = cent_q;
endmodule : rsf_flags_top

// [tb/rsf_flags_monitor.sv]
`timescale 1ns/1ps
`include "rsf_map.svh"
// ****
// Flag and century checker.
// ****
module rsf_flags_monitor
   import rsf_pkg::*;
#(
   parameter int unsigned OSC_WAIT_CYC = 50,
   parameter int unsigned XFER_CYC     = 5
) (
   input wire logic        clk,
   input wire logic        rst,
   input wire logic        psel,
   input wire logic        penable,
   input wire logic        pwrite,
   input wire logic [31:0] paddr,
   input wire logic [31:0] pwdata,
   input wire logic [3:0]  pstrb,
   input wire logic [31:0] prdata,
   input wire logic        osc_enable,
   input wire logic        osc_tick,
   input wire logic        power_fail_event,
   input wire logic        oscillator_fail_flag,
   input wire logic        power_fail_flag,
   input wire logic [7:0]  century_count
);
   logic       acc, rdf, wrc, clr;
   logic [7:0] wcnt_q, wcnt_d, qcnt_q, qcnt_d;
   assign acc = psel && penable;
   assign rdf = acc && !pwrite && paddr == `RSF_OFF_FLAGS_B;
   assign wrc = acc && pwrite && pstrb[0] && paddr == `RSF_OFF_CENT_BYTE;
   assign clr = acc && pwrite && pstrb[0] && paddr == `RSF_OFF_FLAGS_B && !pwdata[`RSF_BIT_OSCILLATOR_FAIL_FLAG];
   // Both counters saturate, so one long quiet spell cannot wrap into a false match.
   always_comb begin
      wcnt_d = (wcnt_q != 8'h00 && wcnt_q != 8'hff) ? wcnt_q + 8'h01 : wcnt_q;
      if (clr) begin
         wcnt_d = 8'h01;
      end
      qcnt_d = (qcnt_q < 8'hfe) ? qcnt_q + 8'h01 : qcnt_q;
      if (osc_tick || !osc_enable) begin
         qcnt_d = 8'hff;
      end
   end
   always_ff @(posedge clk) begin
      wcnt_q <= rst ? 8'h00 : wcnt_d;
      qcnt_q <= rst ? 8'h00 : qcnt_d;
   end
   default clocking cb @(posedge clk); endclocking
   default disable iff (rst);
   AST_CENT_RANGE: assert property (century_count <= 8'h09)
      else $error("century out of range");
   AST_CENT_WR: assert property (wrc && pwdata[7:0] <= 8'h09
      |=> century_count == $past(pwdata[7:0])) else $error("century write lost");
   AST_CENT_HOLD: assert property (wrc && pwdata[7:0] > 8'h09
      |=> $stable(century_count)) else $error("bad century stored");
   AST_OSC_SET: assert property (qcnt_q == 8'(OSC_WAIT_CYC + 4)
      |-> oscillator_fail_flag) else $error("oscillator fail not set");
   AST_OSC_KEEP: assert property ($fell(oscillator_fail_flag)
      |-> wcnt_q == 8'(XFER_CYC + 2)) else $error("oscillator fail cleared early");
   AST_PF_CLR: assert property (rdf && !power_fail_event
      |=> power_fail_flag == ($past(power_fail_flag) && !$past(prdata[`RSF_BIT_PF])))
      else $error("power fail kept after read");
   AST_RD_FLAGS: assert property (rdf
      |-> prdata[5:3] == {$past(power_fail_flag), $past(oscillator_fail_flag), 1'b0})
      else $error("flags read wrong");
endmodule : rsf_flags_monitor
bind rsf_flags_top rsf_flags_monitor #(.OSC_WAIT_CYC(OSC_WAIT_CYC), .XFER_CYC(XFER_CYC)) mon (
   .clk, .rst, .psel, .penable, .pwrite, .paddr, .pwdata, .pstrb, .prdata, .osc_enable,
   .osc_tick, .power_fail_event, .oscillator_fail_flag, .power_fail_flag, .century_count);

// [tb/rsf_host.sv]
`timescale 1ns/1ps
// ****
// Host bus master.
// ****
module rsf_host (
   input  wire logic        clk,
   input  wire logic        pready,
   input  wire logic        pslverr,
   input  wire logic [31:0] prdata,
   output logic             psel,
   output logic             penable,
   output logic             pwrite,
   output logic      [31:0] paddr,
   output logic      [31:0] pwdata,
   output logic      [3:0]  pstrb
);
   logic err;
   initial begin
      {psel, penable, pwrite, paddr, pwdata, err} = '0;
      pstrb = 4'hf;
   end
   // An idle edge first keeps back-to-back calls from driving psel twice in one step.
   task automatic xfer(input logic w, input logic [31:0] a, d, output logic [31:0] r);
      @(posedge clk);
      psel <= 1'b1;
      pwrite <= w;
      paddr <= a;
      pwdata <= d;
      @(posedge clk);
      penable <= 1'b1;
      do @(posedge clk); while (pready !== 1'b1);
      r = prdata;
      err = pslverr;
      psel <= 1'b0;
      penable <= 1'b0;
   endtask : xfer
endmodule : rsf_host

// [tb/test_rsf_flags_top.sv]
`timescale 1ns/1ps
`include "rsf_map.svh"
module test_rsf_flags_top;
   import rsf_pkg::*;
   logic        clk, rst, osc_enable, osc_tick, power_fail_event, oscillator_fail_flag_retained, tick_on;
   logic        psel, penable, pwrite, pready, pslverr, oscillator_fail_flag, power_fail_flag;
   logic [31:0] paddr, pwdata, prdata, rd;
   logic [3:0]  pstrb;
   logic [7:0]  century_count;
   int          bad_count = 0;
   int          checked = 0;
   localparam logic [31:0] F = `RSF_OFF_FLAGS_B;
   localparam logic [31:0] C = `RSF_OFF_CENT_BYTE;
   localparam logic [31:0] S = `RSF_OFF_STATUS;
   rsf_flags_top #(.OSC_WAIT_CYC(50), .XFER_CYC(5)) dut (.clk, .rst, .psel, .penable, .pwrite,
      .paddr, .pwdata, .pstrb, .prdata, .pready, .pslverr, .osc_enable, .osc_tick,
      .power_fail_event, .oscillator_fail_flag_retained, .oscillator_fail_flag, .power_fail_flag,
      .century_count);
   rsf_host host (.clk, .pready, .pslverr, .prdata, .psel, .penable, .pwrite, .paddr,
      .pwdata, .pstrb);
   initial begin
      clk = 1'b0;
      forever #2 clk = ~clk;
   end
   always @(posedge clk) osc_tick <= tick_on && !osc_tick;
   task automatic cmp(input logic [31:0] got, exp);
      checked++;
      if (got !== exp) begin
         bad_count++;
         $display("ERROR %0t got %h exp %h", $time, got, exp);
      end
   endtask : cmp
   task automatic do_reset(input logic en, ret);
      osc_enable <= en;
      oscillator_fail_flag_retained <= ret;
      rst <= 1'b1;
      repeat (8) @(posedge clk);
      rst <= 1'b0;
   endtask : do_reset
   task automatic tally_and_finish;
      $display("checked %0d mismatches %0d", checked, bad_count);
      if (bad_count == 0 && checked > 0) begin
         $display("TEST PASSED");
      end else begin
         $display("TEST FAILED");
      end
      $finish;
   endtask : tally_and_finish
   initial begin
      repeat (3000) @(posedge clk);
      bad_count++;
      tally_and_finish();
   end
   initial begin
      {rst, osc_enable, power_fail_event, oscillator_fail_flag_retained, tick_on} = 5'h10;
      do_reset(1'b0, 1'b0);
      host.xfer(1'b0, F, 32'h0, rd);
      cmp(rd, 32'h0);
      host.xfer(1'b1, C, 32'h9, rd);
      host.xfer(1'b1, C, 32'h0a, rd);
      host.xfer(1'b1, C, 32'h10, rd);
      host.xfer(1'b1, C, 32'h99, rd);
      host.xfer(1'b0, C, 32'h0, rd);
      cmp(rd, 32'h9);
      host.xfer(1'b1, F, 32'h08, rd);
      host.xfer(1'b0, F, 32'h0, rd);
      cmp(rd, 32'h0);
      host.xfer(1'b0, 32'h10, 32'h0, rd);
      cmp({31'h0, host.err}, 32'h1);
      $display("registers done");
      @(posedge clk) power_fail_event <= 1'b1;
      @(posedge clk) power_fail_event <= 1'b0;
      host.xfer(1'b0, F, 32'h0, rd);
      cmp(rd, 32'h20);
      host.xfer(1'b0, F, 32'h0, rd);
      cmp(rd, 32'h0);
      @(posedge clk) power_fail_event <= 1'b1;
      do_reset(1'b1, 1'b0);
      power_fail_event <= 1'b0;
      #1 cmp({31'h0, power_fail_flag}, 32'h0);
      repeat (20) @(posedge clk);
      #1 cmp({31'h0, oscillator_fail_flag}, 32'h0);
      repeat (40) @(posedge clk);
      #1 cmp({31'h0, oscillator_fail_flag}, 32'h1);
      host.xfer(1'b1, F, 32'h0, rd);
      host.xfer(1'b0, S, 32'h0, rd);
      cmp(rd, 32'h3);
      repeat (2) @(posedge clk);
      #1 cmp({31'h0, oscillator_fail_flag}, 32'h1);
      repeat (2) @(posedge clk);
      #1 cmp({31'h0, oscillator_fail_flag}, 32'h0);
      $display("start-up check done");
      tick_on <= 1'b1;
      do_reset(1'b1, 1'b1);
      repeat (70) @(posedge clk);
      host.xfer(1'b0, F, 32'h0, rd);
      cmp(rd, 32'h10);
      host.xfer(1'b1, F, 32'h0, rd);
      repeat (8) @(posedge clk);
      #1 cmp({31'h0, oscillator_fail_flag}, 32'h0);
      $display("retained flag done");
      tally_and_finish();
   end
endmodule : test_rsf_flags_top
